// [nvr_pkg.sv]
package nvr_pkg;
   localparam int NUM_BANKS      = 8;
   localparam int BANK_BITS      = 128;
   localparam int BYTE_W         = 8;
   localparam int BYTES_PER_BANK = BANK_BITS / BYTE_W;
   localparam int BANK_AW        = 3;
   localparam int BYTE_AW        = 4;
   localparam int ADDR_W         = BANK_AW + BYTE_AW;
   localparam int DEPTH          = NUM_BANKS * BYTES_PER_BANK;
   localparam int BANK_LSB       = BYTE_AW;
   localparam int BYTE_LSB       = 0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef struct packed {
      logic [BANK_AW-1:0] bank;
      logic [BYTE_AW-1:0] byte_idx;
   } nvr_addr_t;

   // programming-port load request, one byte per cycle
   typedef struct packed {
      logic               erase;
      logic               write;
      logic               decrypt;
      logic [ADDR_W-1:0]  addr;
      logic [BYTE_W-1:0]  wdata;
   } nvr_prog_t;

   // decryption engine result for a byte flagged for decryption
   typedef struct packed {
      logic [BYTE_W-1:0]  plain;
   } nvr_dec_t;
endpackage

// [nvr_user_rom.sv]
`timescale 1ns/100ps
// Summary of operation
// - storage is eight banks of 128 bits each, 1 kbit in all.
// - user logic reads one byte per access over a port synchronous to ref_clk.
// - address bits 6:4 pick the bank and bits 3:0 pick the byte in that bank.
// - erase and write come only through the programming port, never from user logic.
// - contents can be read back both through the programming port and by user addressing.
// - loaded data can optionally pass through the on-chip decryption engine.
module nvr_user_rom (
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   input  wire logic [nvr_pkg::ADDR_W-1:0]  user_addr,
   output logic      [nvr_pkg::BYTE_W-1:0]  user_rdata,
   input  wire nvr_pkg::nvr_prog_t          prog_req,
   input  wire nvr_pkg::nvr_dec_t           dec_out,
   output nvr_pkg::nvr_prog_t               dec_in,
   input  wire logic [nvr_pkg::ADDR_W-1:0]  prog_raddr,
   output logic      [nvr_pkg::BYTE_W-1:0]  prog_rdata
);
   // flip-flop storage; in silicon this is a nonvolatile array, so reset
   // does not clear it here either; a blank array reads as the erased value
   logic [nvr_pkg::BYTE_W-1:0] mem [nvr_pkg::DEPTH] = '{default: nvr_pkg::BYTE_RESET};

   nvr_pkg::nvr_addr_t           ua;
   logic [nvr_pkg::BANK_AW-1:0]  user_bank;
   logic [nvr_pkg::BYTE_AW-1:0]  user_byte;
   logic [nvr_pkg::ADDR_W-1:0]   user_index;
   logic [nvr_pkg::BANK_AW-1:0]  prog_bank;
   logic [nvr_pkg::BANK_AW-1:0]  pend_bank;
   logic                         pend_dec;
   logic [nvr_pkg::ADDR_W-1:0]   pend_addr;
   logic                         dec_req;
   logic                         plain_wr;
   logic                         dec_wr;
   logic                         any_wr;
   logic [nvr_pkg::BYTE_W-1:0]   next_byte;
   logic [nvr_pkg::ADDR_W-1:0]   wr_addr;

   assign ua         = nvr_pkg::nvr_addr_t'(user_addr);
   assign user_bank  = ua.bank;
   assign user_byte  = ua.byte_idx;
   assign user_index = {user_bank, user_byte};
   assign prog_bank  = prog_req.addr[nvr_pkg::ADDR_W-1:nvr_pkg::BANK_LSB];
   assign pend_bank  = pend_addr[nvr_pkg::ADDR_W-1:nvr_pkg::BANK_LSB];
   // only prog_req can modify the array; there is no user write path
   assign plain_wr   = prog_req.write & ~prog_req.decrypt;
   // an erase in the same request cancels the decryption round trip
   assign dec_req    = prog_req.write & prog_req.decrypt & ~prog_req.erase;
   assign dec_wr     = pend_dec;
   // the returning decrypted byte wins over a plain write in the same cycle
   assign any_wr     = plain_wr | dec_wr;
   assign wr_addr    = dec_wr ? pend_addr : prog_req.addr;
   assign next_byte  = dec_wr ? dec_out.plain : prog_req.wdata;

   // decrypted bytes return one cycle later; a plain write colliding with
   // that return is dropped, so the loader must leave a gap after it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pend_dec  <= 1'b0;
         pend_addr <= '0;
         dec_in    <= '0;
      end else begin
         pend_dec  <= dec_req;
         pend_addr <= prog_req.addr;
         dec_in    <= prog_req;
      end
   end

   // erase clears the whole addressed bank; it has priority over writes
   genvar gi;
   generate
      for (gi = 0; gi < nvr_pkg::DEPTH; gi++) begin : g_cell
         localparam int CELL = gi;
         logic erase_hit;
         logic write_hit;
         assign erase_hit = prog_req.erase &&
                            (prog_bank == CELL[nvr_pkg::ADDR_W-1:nvr_pkg::BANK_LSB]);
         assign write_hit = any_wr && (wr_addr == CELL[nvr_pkg::ADDR_W-1:0]);
         always_ff @(posedge ref_clk) begin
            if (erase_hit) begin
               mem[gi] <= nvr_pkg::BYTE_RESET;
            end else if (write_hit) begin
               mem[gi] <= next_byte;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         user_rdata <= nvr_pkg::BYTE_RESET;
         prog_rdata <= nvr_pkg::BYTE_RESET;
      end else begin
         user_rdata <= mem[user_index];
         prog_rdata <= mem[prog_raddr];
      end
   end

   // a read always returns the byte held before the edge, even mid-load
   property p_user_read;
      @(posedge ref_clk) disable iff (!nrst)
      nrst
      |=> user_rdata == $past(mem[user_index]);
   endproperty
   a_user_read: assert property (p_user_read) else $error("user read byte wrong");

   // readback port follows its own address one cycle later
   property p_prog_read;
      @(posedge ref_clk) disable iff (!nrst)
      nrst
      |=> prog_rdata == $past(mem[prog_raddr]);
   endproperty
   a_prog_read: assert property (p_prog_read) else $error("readback byte wrong");

   // with no load in flight the user-addressed byte cannot move
   property p_hold;
      @(posedge ref_clk) disable iff (!nrst)
      !prog_req.erase && !prog_req.write && !pend_dec
      |=> mem[$past(user_index)] == $past(mem[user_index]);
   endproperty
   a_hold: assert property (p_hold) else $error("array changed with no load");

   // same for the byte addressed by the readback port
   property p_hold_readback;
      @(posedge ref_clk) disable iff (!nrst)
      !prog_req.erase && !prog_req.write && !pend_dec
      |=> mem[$past(prog_raddr)] == $past(mem[prog_raddr]);
   endproperty
   a_hold_readback: assert property (p_hold_readback) else $error("readback byte moved");

   // decrypted byte lands at the second edge unless an erase intervenes
   property p_decrypt;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && dec_req ##1 !prog_req.erase
      |=> mem[$past(prog_req.addr, 2)] == $past(dec_out.plain);
   endproperty
   a_decrypt: assert property (p_decrypt) else $error("decrypted byte not stored");

   // a returning decrypted byte is written to the address it was sent with
   property p_dec_return;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && pend_dec && !prog_req.erase
      |=> mem[$past(pend_addr)] == $past(dec_out.plain);
   endproperty
   a_dec_return: assert property (p_dec_return) else $error("decrypted byte misplaced");

   // a plain write with no collision is visible after its edge
   property p_plain_write;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && plain_wr && !prog_req.erase && !pend_dec
      |=> mem[$past(prog_req.addr)] == $past(prog_req.wdata);
   endproperty
   a_plain_write: assert property (p_plain_write) else $error("plain byte not stored");

   // erase clears the first byte of its bank
   property p_erase_first;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && prog_req.erase
      |=> mem[{$past(prog_bank), {nvr_pkg::BYTE_AW{1'b0}}}] == nvr_pkg::BYTE_RESET;
   endproperty
   a_erase_first: assert property (p_erase_first) else $error("bank start not erased");

   // erase clears the last byte of its bank
   property p_erase_last;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && prog_req.erase
      |=> mem[{$past(prog_bank), {nvr_pkg::BYTE_AW{1'b1}}}] == nvr_pkg::BYTE_RESET;
   endproperty
   a_erase_last: assert property (p_erase_last) else $error("bank end not erased");

   // erase beats any write that targets the same bank
   property p_erase_beats_write;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && prog_req.erase && any_wr &&
      (wr_addr[nvr_pkg::ADDR_W-1:nvr_pkg::BANK_LSB] == prog_bank)
      |=> mem[$past(wr_addr)] == nvr_pkg::BYTE_RESET;
   endproperty
   a_erase_beats_write: assert property (p_erase_beats_write) else $error("write beat erase");

   // banks are independent: erasing one leaves another alone
   property p_erase_other_bank;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && prog_req.erase && !any_wr && (user_bank != prog_bank)
      |=> mem[$past(user_index)] == $past(mem[user_index]);
   endproperty
   a_erase_other_bank: assert property (p_erase_other_bank) else $error("other bank changed");

   // a plain write behind a decrypted one is dropped, its target kept
   property p_drop;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && pend_dec && plain_wr && !prog_req.erase && (prog_req.addr != pend_addr)
      |=> mem[$past(prog_req.addr)] == $past(mem[prog_req.addr]);
   endproperty
   a_drop: assert property (p_drop) else $error("colliding plain write stored");

   // the decryption engine sees each request one cycle later
   property p_dec_fwd;
      @(posedge ref_clk) disable iff (!nrst)
      nrst
      |=> dec_in == $past(prog_req);
   endproperty
   a_dec_fwd: assert property (p_dec_fwd) else $error("engine input not forwarded");

   // a decrypt round trip is pending exactly after a decrypt request
   property p_pend_set;
      @(posedge ref_clk) disable iff (!nrst)
      nrst
      |=> pend_dec == $past(dec_req);
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("decrypt pending flag wrong");

   // the pending address is that of the decrypt request
   property p_pend_addr;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && dec_req
      |=> pend_addr == $past(prog_req.addr);
   endproperty
   a_pend_addr: assert property (p_pend_addr) else $error("decrypt address lost");

   // erase in the request suppresses its decryption round trip
   property p_erase_cancels;
      @(posedge ref_clk) disable iff (!nrst)
      nrst && prog_req.erase
      |=> !pend_dec;
   endproperty
   a_erase_cancels: assert property (p_erase_cancels) else $error("erase left decrypt pending");
endmodule

// [nvr_dec_model.sv]
`timescale 1ns/100ps
module nvr_dec_model #(
   parameter logic [7:0] KEY = 8'h5a
) (
   input  wire nvr_pkg::nvr_prog_t dec_in,
   output nvr_pkg::nvr_dec_t       dec_out
);
   // xor keeps the engine trivial but still makes plain differ from cipher
   assign dec_out.plain = dec_in.wdata ^ KEY;
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb;
   localparam logic [7:0] KEY = 8'h5a;
   logic               ref_clk = 1'b0;
   logic               nrst = 1'b0;
   logic [6:0]         user_addr = '0;
   logic [6:0]         prog_raddr = '0;
   logic [7:0]         user_rdata;
   logic [7:0]         prog_rdata;
   nvr_pkg::nvr_prog_t prog_req = '0;
   nvr_pkg::nvr_prog_t dec_in;
   nvr_pkg::nvr_dec_t  dec_out;
   int                 n_mismatch = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;
   logic [6:0]         row_a [4] = '{7'h00, 7'h0f, 7'h10, 7'h7f};
   logic [7:0]         row_d [4] = '{8'ha5, 8'h3c, 8'hff, 8'h81};
   nvr_user_rom dut (.ref_clk(ref_clk), .nrst(nrst), .user_addr(user_addr),
      .user_rdata(user_rdata), .prog_req(prog_req), .dec_out(dec_out),
      .dec_in(dec_in), .prog_raddr(prog_raddr), .prog_rdata(prog_rdata));
   nvr_dec_model #(.KEY(KEY)) eng (.dec_in(dec_in), .dec_out(dec_out));
   always #50 ref_clk = ~ref_clk;
   task conclude;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t byte %h want %h", $time, got, exp);
      end
   endtask
   // clearing the request at the second edge leaves the gap a decrypted write needs
   task wr(input logic e, input logic w, input logic d, input logic [6:0] a,
           input logic [7:0] v);
      @(posedge ref_clk) prog_req <= '{e, w, d, a, v};
      @(posedge ref_clk) prog_req <= '0;
      @(posedge ref_clk);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] exp);
      @(posedge ref_clk) begin
         user_addr <= a;
         prog_raddr <= a;
      end
      @(posedge ref_clk) #1;
      chk(user_rdata, exp);
      chk(prog_rdata, exp);
   endtask
   initial begin
      @(posedge ref_clk) #1;
      chk(user_rdata, 8'h00);
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) wr(1'b0, 1'b1, 1'b0, row_a[i], row_d[i]);
      for (int i = 0; i < 4; i++) rd(row_a[i], row_d[i]);
      wr(1'b0, 1'b1, 1'b1, 7'h21, 8'h96);
      rd(7'h21, 8'h96 ^ KEY);
      // erase bank 0 must leave bank 1 untouched
      wr(1'b1, 1'b0, 1'b0, 7'h0f, 8'h00);
      rd(7'h00, 8'h00);
      rd(7'h0f, 8'h00);
      rd(7'h10, 8'hff);
      // a plain write right behind a decrypted one is dropped
      @(posedge ref_clk) prog_req <= '{1'b0, 1'b1, 1'b1, 7'h30, 8'h11};
      @(posedge ref_clk) prog_req <= '{1'b0, 1'b1, 1'b0, 7'h31, 8'h22};
      @(posedge ref_clk) prog_req <= '0;
      @(posedge ref_clk);
      rd(7'h30, 8'h11 ^ KEY);
      rd(7'h31, 8'h00);
      // reset in mid-run clears the outputs but not the array
      @(posedge ref_clk) nrst <= 1'b0;
      @(posedge ref_clk) #1;
      chk(user_rdata, 8'h00);
      chk(prog_rdata, 8'h00);
      @(posedge ref_clk) nrst <= 1'b1;
      rd(7'h10, 8'hff);
      conclude;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 400) begin
         n_mismatch++;
         conclude;
      end
   end
endmodule
